// *** test/acrc_checker.sv ***
// Port assertions for the clock and reference control block.
`timescale 1ns/100ps
module acrc_checker #(
  parameter int unsigned BLANK_CYCLES = 8
) (
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Inputs
  input wire logic                cfg_wr,
  input wire acrc_pkg::acrc_cfg_s cfg_in,
  input wire logic                start_in,
  input wire logic                reset_req_in,
  input wire logic                mod_saturate,
  input wire logic                conv_done,
  // Outputs
  input wire logic                sys_clk_tick,
  input wire logic                mod_clk_tick,
  input wire acrc_pkg::acrc_cfg_s cfg_out,
  input wire logic                inp_rng_eff,
  input wire logic                ll_osr_mid_force,
  input wire logic                cfg_illegal,
  input wire logic                start_out,
  input wire logic                reset_req_out,
  input wire logic                ctrl_blanked,
  input wire logic                modulator_saturation_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Saturation seen since the last conversion end, the flag's expected source.
  logic sat_q;
  logic sat_d;
  logic hit;
  always_comb hit = sat_q | mod_saturate;
  always_comb sat_d = conv_done ? 1'b0 : hit;
  always_ff @(posedge clk) sat_q <= rst_n ? sat_d : 1'b0;
  // Cycles the control pins have stood blanked in a row.
  logic [31:0] blank_n;
  always_ff @(posedge clk) blank_n <= (rst_n && ctrl_blanked) ? blank_n + 32'h0000_0001 : 32'h0000_0000;
  sequence s_swap;
    cfg_wr && cfg_in.clk_sel != cfg_out.clk_sel;
  endsequence
  reset_default_a: assert property (disable iff (1'b0) !rst_n |=> cfg_out.clk_sel == 1'b0 && !ctrl_blanked)
    else $error("clock select or blanking not cleared by reset");
  config_load_a: assert property (cfg_wr |=> cfg_out == $past(cfg_in))
    else $error("configuration not loaded");
  swap_blank_a: assert property (s_swap |-> ##2 ctrl_blanked[*8])
    else $error("control pins not blanked after source change");
  blank_len_a: assert property (!ctrl_blanked && $past(ctrl_blanked) |-> blank_n >= BLANK_CYCLES + 1)
    else $error("blanking ended too early");
  gate_blank_a: assert property (ctrl_blanked |-> !start_out && !reset_req_out)
    else $error("control pin passed while blanked");
  gate_pass_a: assert property (!ctrl_blanked |-> start_out == start_in && reset_req_out == reset_req_in)
    else $error("control pin lost while not blanked");
  mod_half_a: assert property (mod_clk_tick |-> $past(sys_clk_tick))
    else $error("modulator tick without system tick before it");
  force_mid_a: assert property (ll_osr_mid_force == (cfg_out.div_code inside {3'h1, 3'h4}))
    else $error("mid-speed ratio force wrong");
  range_force_a: assert property (inp_rng_eff == (cfg_out.reference_range_select ? 1'b0 : cfg_out.inp_rng))
    else $error("effective input range wrong");
  illegal_cfg_a: assert property (cfg_illegal == (cfg_out.speed == acrc_pkg::ACRC_SPD_MAX && !cfg_out.clk_sel))
    else $error("illegal source flag wrong");
  sat_latch_a: assert property (conv_done |=> modulator_saturation_flag == $past(hit))
    else $error("saturation flag not refreshed");
  sat_hold_a: assert property (!conv_done |=> $stable(modulator_saturation_flag))
    else $error("saturation flag moved between conversions");
endmodule : acrc_checker
bind acrc_top acrc_checker #(.BLANK_CYCLES(BLANK_CYCLES)) u_chk (.clk, .rst_n, .cfg_wr, .cfg_in, .start_in,
  .reset_req_in, .mod_saturate, .conv_done, .sys_clk_tick, .mod_clk_tick, .cfg_out, .inp_rng_eff,
  .ll_osr_mid_force, .cfg_illegal, .start_out, .reset_req_out, .ctrl_blanked, .modulator_saturation_flag);

// *** test/acrc_src_model.sv ***
// Clock source model: internal oscillator and external clock pin as ticks.
`timescale 1ns/100ps
module acrc_src_model #(
  parameter int unsigned OSC_DIV = 2,
  parameter int unsigned EXT_DIV = 3
) (
  // Clock
  input wire logic clk,
  // External clock enable from the host side
  input wire logic ext_on,
  // Source ticks
  output logic     osc_tick,
  output logic     ext_clk_tick
);
  int osc_n = 0;
  int ext_n = 0;
  initial osc_tick = 1'b0;
  initial ext_clk_tick = 1'b0;
  // The external clock stands still while disabled, so a late enable is seen.
  always @(negedge clk)
  begin
    osc_n = (osc_n + 1) % OSC_DIV;
    osc_tick <= osc_n == 0;
    ext_n = ext_on ? (ext_n + 1) % EXT_DIV : 0;
    ext_clk_tick <= ext_on && ext_n == 0;
  end
endmodule : acrc_src_model

// *** test/acrc_top_test.sv ***
// Self-checking bench for the clock and reference control block.
`timescale 1ns/100ps
module acrc_top_test;
  logic                clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                ext_on = 1'b0;
  logic                cfg_wr = 1'b0;
  acrc_pkg::acrc_cfg_s cfg_in = '0;
  logic                start_in = 1'b0;
  logic                reset_req_in = 1'b0;
  logic                mod_saturate = 1'b0;
  logic                conv_done = 1'b0;
  logic                osc_tick, ext_clk_tick, sys_clk_tick, mod_clk_tick, inp_rng_eff;
  logic                ll_osr_mid_force, cfg_illegal, start_out, reset_req_out, ctrl_blanked;
  logic                modulator_saturation_flag;
  acrc_pkg::acrc_cfg_s cfg_out;
  int                  n_fail = 0;
  int                  total_checks = 0;
  int                  p;
  always #25 clk = ~clk;
  acrc_src_model i_src (.clk, .ext_on, .osc_tick, .ext_clk_tick);
  acrc_top #(.BLANK_CYCLES(8)) i_dut (.clk, .rst_n, .osc_tick, .ext_clk_tick, .cfg_wr, .cfg_in, .start_in,
    .reset_req_in, .mod_saturate, .conv_done, .sys_clk_tick, .mod_clk_tick, .cfg_out, .inp_rng_eff,
    .ll_osr_mid_force, .cfg_illegal, .start_out, .reset_req_out, .ctrl_blanked, .modulator_saturation_flag);
  task chk(input string n, input logic [8:0] e, input logic [8:0] s);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] v);
    cfg_in = acrc_pkg::acrc_cfg_s'(v);
    cfg_wr = 1'b1;
    @(negedge clk);
    cfg_wr = 1'b0;
    @(negedge clk);
    chk("cfg_out", {1'b0, v}, {1'b0, cfg_out});
  endtask : wr
  // Counts cycles between two ticks; the first wait skips a partial period.
  task per(input bit m, output int q);
    int i;
    i = 0;
    while ((m ? mod_clk_tick : sys_clk_tick) !== 1'b1 && i < 80)
    begin
      @(negedge clk);
      i++;
    end
    q = 0;
    do
    begin
      @(negedge clk);
      q++;
    end while ((m ? mod_clk_tick : sys_clk_tick) !== 1'b1 && q < 80);
  endtask : per
  task unblank(output int n);
    n = 0;
    while (ctrl_blanked !== 1'b0 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask : unblank
  task test_done;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  initial
  begin
    #(4000 * 50);
    n_fail++;
    test_done();
  end
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    chk("cfg_reset", 9'h002, {1'b0, cfg_out});
    chk("blank_reset", 9'h0, {8'h0, ctrl_blanked});
    per(0, p);
    chk("osc_period", 9'h2, 9'(p));
    per(1, p);
    chk("mod_period", 9'h4, 9'(p));
    $display("test reset finished");
    for (int d = 0; d < 5; d++)
    begin
      wr({1'b0, 3'(d), 4'h2});
      chk("mid_force", 9'(d == 1 || d == 4), {8'h0, ll_osr_mid_force});
      per(0, p);
      per(0, p);
      chk("sys_period", 9'(2 << d), 9'(p));
    end
    $display("test divider finished");
    wr(8'h0e);
    chk("inp_rng_eff", 9'h0, {8'h0, inp_rng_eff});
    wr(8'h06);
    chk("inp_rng_eff", 9'h1, {8'h0, inp_rng_eff});
    wr(8'h03);
    chk("illegal", 9'h1, {8'h0, cfg_illegal});
    $display("test ranges finished");
    ext_on = 1'b1;
    repeat (6) @(negedge clk);
    start_in = 1'b1;
    reset_req_in = 1'b1;
    wr(8'h83);
    chk("illegal", 9'h0, {8'h0, cfg_illegal});
    chk("blanked", 9'h1, {8'h0, ctrl_blanked});
    chk("start_gate", 9'h0, {7'h0, start_out, reset_req_out});
    unblank(p);
    chk("blank_len", 9'h1, 9'(p >= 8 && p < 200));
    chk("start_pass", 9'h3, {7'h0, start_out, reset_req_out});
    per(0, p);
    chk("ext_period", 9'h3, 9'(p));
    per(1, p);
    chk("ext_mod_period", 9'h6, 9'(p));
    wr(8'h02);
    chk("blanked", 9'h1, {8'h0, ctrl_blanked});
    repeat (20) @(negedge clk);
    ext_on = 1'b0;
    unblank(p);
    per(0, p);
    chk("back_period", 9'h2, 9'(p));
    $display("test source switch finished");
    mod_saturate = 1'b1;
    @(negedge clk);
    mod_saturate = 1'b0;
    repeat (3) @(negedge clk);
    conv_done = 1'b1;
    @(negedge clk);
    conv_done = 1'b0;
    chk("sat_flag", 9'h1, {8'h0, modulator_saturation_flag});
    repeat (3) @(negedge clk);
    conv_done = 1'b1;
    @(negedge clk);
    conv_done = 1'b0;
    chk("sat_flag", 9'h0, {8'h0, modulator_saturation_flag});
    $display("test saturation finished");
    test_done();
  end
endmodule : acrc_top_test

// *** verilog/acrc_clk_div.sv ***
// Glitch-free power-of-two clock-enable divider.
`timescale 1ns/100ps
module acrc_clk_div #(
  parameter int unsigned CODE_W = 3
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Source tick and ratio
  input  wire logic              src_tick,
  input  wire logic [CODE_W-1:0] div_code,
  // Divided tick
  output logic                   out_tick
);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // The ratio is only taken when the count wraps, so a change never shortens a period.
  logic [15:0]       cnt_q, cnt_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic              tick_q, tick_d;
  logic [15:0]       last;

  always_comb
  begin
    last   = (16'h0001 << code_q) - 16'h0001;
    cnt_d  = cnt_q;
    code_d = code_q;
    tick_d = 1'b0;
    if (src_tick)
    begin
      if (cnt_q >= last)
      begin
        cnt_d  = 16'h0000;
        code_d = div_code;
        tick_d = 1'b1;
      end
      else
      begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q  <= 16'h0000;
      code_q <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      code_q <= code_d;
      tick_q <= tick_d;
    end
  end

  assign out_tick = tick_q;

endmodule : acrc_clk_div

// *** verilog/acrc_pkg.sv ***
// Package with constants and types for the converter clock and reference control block.
package acrc_pkg;

  // ----------------------------------------------------------------
  // Clock rates and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ     = 20000000;
  localparam int unsigned BLANK_TIME_US   = 150;
  // Least time in whole cycles; the MHz rate is truncated and nothing is added to round up.
  localparam int unsigned BLANK_CYCLES    = (BLANK_TIME_US * (CLK_FREQ_HZ / 1000000) + 0) ;
  localparam int unsigned OSC_FREQ_KHZ    = 25600;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic       CLK_SEL_RESET    = 1'b0;
  localparam logic       CLK_SEL_EXT      = 1'b1;
  localparam logic [2:0] DIV_RATIO_RESET  = 3'h0;
  localparam logic       REFERENCE_RANGE_SELECT_LOW      = 1'b0;
  localparam logic       INP_RNG_1X       = 1'b0;

  // Divider ratio codes: 1, 2, 4, 8, 16 (power of two exponent).
  localparam logic [2:0] DIV_CODE_1       = 3'h0;
  localparam logic [2:0] DIV_CODE_2       = 3'h1;
  localparam logic [2:0] DIV_CODE_16      = 3'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACRC_SPD_LOW  = 2'b00,
    ACRC_SPD_MID  = 2'b01,
    ACRC_SPD_HIGH = 2'b10,
    ACRC_SPD_MAX  = 2'b11
  } acrc_speed_e;

  typedef enum logic [1:0] {
    ACRC_ST_RUN    = 2'b00,
    ACRC_ST_SWITCH = 2'b01,
    ACRC_ST_BLANK  = 2'b10
  } acrc_state_e;

  typedef struct packed {
    logic        clk_sel;
    logic [2:0]  div_code;
    logic        reference_range_select;
    logic        inp_rng;
    acrc_speed_e speed;
  } acrc_cfg_s;

endpackage : acrc_pkg

// *** verilog/acrc_top.sv ***
// Clock source selection, division, reference range and saturation flag control.
`timescale 1ns/100ps
module acrc_top #(
  parameter int unsigned BLANK_CYCLES = acrc_pkg::BLANK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Clock sources as one-cycle ticks
  input  wire logic              osc_tick,
  input  wire logic              ext_clk_tick,
  // Configuration
  input  wire logic              cfg_wr,
  input  wire acrc_pkg::acrc_cfg_s cfg_in,
  // Control pins
  input  wire logic              start_in,
  input  wire logic              reset_req_in,
  // Modulator status
  input  wire logic              mod_saturate,
  input  wire logic              conv_done,
  // Clock outputs
  output logic                   sys_clk_tick,
  output logic                   mod_clk_tick,
  // Status and effective settings
  output acrc_pkg::acrc_cfg_s    cfg_out,
  output logic                   inp_rng_eff,
  output logic                   ll_osr_mid_force,
  output logic                   cfg_illegal,
  output logic                   start_out,
  output logic                   reset_req_out,
  output logic                   ctrl_blanked,
  output logic                   modulator_saturation_flag
);

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  acrc_pkg::acrc_cfg_s cfg_q, cfg_d;
  logic                src_sel_q, src_sel_d;
  acrc_pkg::acrc_state_e st_q, st_d;
  // The hold counter is kept wide so that a faster clock or longer hold still fits.
  logic [31:0]         blank_q, blank_d;

  always_comb
  begin
    cfg_d = cfg_q;
    if (cfg_wr)
    begin
      cfg_d = cfg_in;
    end
  end

  // ----------------------------------------------------------------
  // Source switch and blanking
  // ----------------------------------------------------------------
  // The switch waits for a tick of the new source, so the divider never sees
  // a partial period from either source.
  always_comb
  begin
    src_sel_d = src_sel_q;
    st_d      = st_q;
    blank_d   = blank_q;
    case (st_q)
      acrc_pkg::ACRC_ST_RUN:
      begin
        if (cfg_q.clk_sel != src_sel_q)
        begin
          st_d = acrc_pkg::ACRC_ST_SWITCH;
        end
      end
      acrc_pkg::ACRC_ST_SWITCH:
      begin
        if ((cfg_q.clk_sel ? ext_clk_tick : osc_tick))
        begin
          src_sel_d = cfg_q.clk_sel;
          blank_d   = BLANK_CYCLES;
          st_d      = acrc_pkg::ACRC_ST_BLANK;
        end
      end
      acrc_pkg::ACRC_ST_BLANK:
      begin
        if (blank_q <= 32'h0000_0001)
        begin
          blank_d = 32'h0000_0000;
          st_d    = acrc_pkg::ACRC_ST_RUN;
        end
        else
        begin
          blank_d = blank_q - 32'h0000_0001;
        end
      end
      default:
      begin
        st_d = acrc_pkg::ACRC_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cfg_q     <= '{clk_sel: acrc_pkg::CLK_SEL_RESET, div_code: acrc_pkg::DIV_RATIO_RESET,
                     reference_range_select: acrc_pkg::REFERENCE_RANGE_SELECT_LOW, inp_rng: acrc_pkg::INP_RNG_1X,
                     speed: acrc_pkg::ACRC_SPD_HIGH};
      src_sel_q <= acrc_pkg::CLK_SEL_RESET;
      st_q      <= acrc_pkg::ACRC_ST_RUN;
      blank_q   <= 32'h0000_0000;
    end
    else
    begin
      cfg_q     <= cfg_d;
      src_sel_q <= src_sel_d;
      st_q      <= st_d;
      blank_q   <= blank_d;
    end
  end

  // ----------------------------------------------------------------
  // Divider and modulator clock
  // ----------------------------------------------------------------
  logic src_tick;
  logic mod_ph_q, mod_ph_d;
  logic mod_q, mod_d;

  // No source ticks pass while switching, so no runt period reaches the divider.
  assign src_tick = (st_q == acrc_pkg::ACRC_ST_SWITCH) ? 1'b0 :
                    (src_sel_q ? ext_clk_tick : osc_tick);

  acrc_clk_div #(
    .CODE_W (3)
  ) u_div (
    .clk      (clk),
    .rst_n    (rst_n),
    .src_tick (src_tick),
    .div_code (cfg_q.div_code),
    .out_tick (sys_clk_tick)
  );

  always_comb
  begin
    mod_ph_d = mod_ph_q;
    mod_d    = 1'b0;
    if (sys_clk_tick)
    begin
      mod_ph_d = ~mod_ph_q;
      mod_d    = mod_ph_q;
    end
  end

  // ----------------------------------------------------------------
  // Saturation flag
  // ----------------------------------------------------------------
  logic sat_acc_q, sat_acc_d;
  logic sat_flag_q, sat_flag_d;
  // A saturation in the cycle of the conversion end still counts for the period that ends.

  always_comb
  begin
    sat_acc_d  = sat_acc_q | mod_saturate;
    sat_flag_d = sat_flag_q;
    if (conv_done)
    begin
      sat_flag_d = sat_acc_q | mod_saturate;
      sat_acc_d  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mod_ph_q   <= 1'b0;
      mod_q      <= 1'b0;
      sat_acc_q  <= 1'b0;
      sat_flag_q <= 1'b0;
    end
    else
    begin
      mod_ph_q   <= mod_ph_d;
      mod_q      <= mod_d;
      sat_acc_q  <= sat_acc_d;
      sat_flag_q <= sat_flag_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mod_clk_tick              = mod_q;
  assign modulator_saturation_flag = sat_flag_q;
  assign cfg_out                   = cfg_q;
  assign ctrl_blanked              = (st_q != acrc_pkg::ACRC_ST_RUN);
  assign start_out                 = start_in & ~ctrl_blanked;
  assign reset_req_out             = reset_req_in & ~ctrl_blanked;
  assign inp_rng_eff               = cfg_q.reference_range_select ? acrc_pkg::INP_RNG_1X : cfg_q.inp_rng;
  assign ll_osr_mid_force          = (cfg_q.div_code == acrc_pkg::DIV_CODE_2) ||
                                     (cfg_q.div_code == acrc_pkg::DIV_CODE_16);
  // Flags maximum speed on the internal oscillator, which is not a permitted setup.
  assign cfg_illegal               = (cfg_q.speed == acrc_pkg::ACRC_SPD_MAX) &&
                                     (cfg_q.clk_sel != acrc_pkg::CLK_SEL_EXT);

endmodule : acrc_top
